// ===== hdl/ums_pkg.sv
// Constants, register map and state type of the master-only SPI serial port.
// Assumes one 100 MHz clock and a plain single-cycle register port.
// Functional notes
// - Mode field 11 selects master SPI; other codes leave the engine idle.
// - Order, phase and polarity take effect in the write that selects SPI.
// - Order bit one sends LSB first; zero sends MSB first.
// - Phase bit picks sampling on leading or trailing clock edge.
// - Polarity bit sets clock idle level and, with phase, the edges.
// - Only master operation; the block always drives the transfer clock.
// - Transmit holding buffer plus shifter; receive has two buffer levels.
// - No write-collision flag; a write while busy lands in the buffer.
// - No double-speed bit; speed comes only from the baud divisor.
// - Serial out is master-out, serial in is master-in, no select pin.
// - Receive flag shows unread data; receiver disable flushes and clears.
// - Transmit-complete sets when shifter and buffer drain; ack or 1 clears.
// - Buffer-empty flag shows free buffer and is set after reset.
// - Each interrupt needs its enable, global enable and its flag.
// - Receiver enable takes the serial-in pin; clearing it flushes data.
// - Receiver alone makes no transfers; only transmitter makes the clock.
// - Transmitter enable takes the pin; clearing waits until all is sent.
// - Data write starts a transfer; buffer moves once shifter is free.
// - Frames are eight bits and may follow back to back.
// - On receive overflow the newest byte is dropped, older ones kept.
// - Framing, overrun and parity flags read as zero.
package ums_pkg;

  localparam logic [3:0] ADDR_STATUS  = 4'h0;
  localparam logic [3:0] ADDR_CTRL    = 4'h1;
  localparam logic [3:0] ADDR_MODE    = 4'h2;
  localparam logic [3:0] ADDR_DATA    = 4'h3;
  localparam logic [3:0] ADDR_BAUD_LO = 4'h4;
  localparam logic [3:0] ADDR_BAUD_HI = 4'h5;

  // Status bits
  localparam int RXC_BIT  = 7;
  localparam int TXC_BIT  = 6;
  localparam int UDRE_BIT = 5;
  // Control bits
  localparam int RXCIE_BIT = 7;
  localparam int TXCIE_BIT = 6;
  localparam int BEIE_BIT  = 5;
  localparam int RXEN_BIT  = 4;
  localparam int TXEN_BIT  = 3;
  // Mode bits
  localparam int MODE_HI_BIT = 7;
  localparam int MODE_LO_BIT = 6;
  localparam int ORDER_BIT   = 2;
  localparam int NATIVE_SPI_PHASE_BIT    = 1;
  localparam int NATIVE_SPI_POLARITY_BIT    = 0;

  localparam logic [1:0] MODE_MSPI  = 2'h3;
  localparam logic [7:0] CTRL_RST   = 8'h00;
  localparam logic [7:0] MODE_RST   = 8'h06;
  localparam logic [11:0] BAUD_RST  = 12'h000;
  localparam logic [3:0] LAST_EDGE  = 4'hf;
  localparam logic [1:0] RX_DEPTH   = 2'h2;

  typedef struct packed {
    logic             rxcie;
    logic             txcie;
    logic             beie;
    logic             rxen;
    logic             txen_req;
    logic             txen_eff;
    logic [1:0]       mode_sel;
    logic             order;
    logic             native_spi_phase;
    logic             native_spi_polarity;
    logic [11:0]      baud;
    logic [7:0]       txbuf;
    logic             txbuf_v;
    logic             busy;
    logic [3:0]       edge_n;
    logic [11:0]      div;
    logic [2:0]       bitn;
    logic [7:0]       txsh;
    logic [7:0]       rxsh;
    logic [1:0][7:0]  rxf;
    logic [1:0]       rxcnt;
    logic             txc;
    logic             sclk;
    logic             mosi;
    logic [7:0]       rdata;
    logic             irq_rxc;
    logic             irq_txc;
    logic             irq_udre;
    logic             miso_s1;
    logic             miso_s2;
  } ums_state_t;

  localparam ums_state_t STATE_RST = '{
    rxcie:    CTRL_RST[RXCIE_BIT],
    txcie:    CTRL_RST[TXCIE_BIT],
    beie:     CTRL_RST[BEIE_BIT],
    rxen:     CTRL_RST[RXEN_BIT],
    txen_req: CTRL_RST[TXEN_BIT],
    txen_eff: CTRL_RST[TXEN_BIT],
    mode_sel: MODE_RST[MODE_HI_BIT:MODE_LO_BIT],
    order:    MODE_RST[ORDER_BIT],
    native_spi_phase:     MODE_RST[NATIVE_SPI_PHASE_BIT],
    native_spi_polarity:     MODE_RST[NATIVE_SPI_POLARITY_BIT],
    sclk:     MODE_RST[NATIVE_SPI_POLARITY_BIT],
    baud:     BAUD_RST,
    default:  '0
  };

endpackage : ums_pkg

// ===== hdl/ums_master_spi.sv
// Master-only SPI engine with register port, tx buffer and two-level rx.
// Assumes register master on i_sys_clk; serial-in pin is asynchronous.
`timescale 1ns/1ps
module ums_master_spi (
  input  wire logic        i_sys_clk,   // System clock, 100 MHz
  input  wire logic        i_srst,      // Synchronous reset, active high
  input  wire logic [3:0]  i_addr,      // Register address
  input  wire logic [7:0]  i_wdata,     // Write data
  input  wire logic        i_wr,        // Write strobe
  input  wire logic        i_rd,        // Read strobe
  output logic      [7:0]  o_rdata,     // Read data, cycle after strobe
  input  wire logic        i_gie,       // Global interrupt enable
  input  wire logic        i_txc_ack,   // Transmit-complete serviced
  output logic             o_irq_rxc,   // Receive-complete interrupt
  output logic             o_irq_txc,   // Transmit-complete interrupt
  output logic             o_irq_udre,  // Buffer-empty interrupt
  output logic             o_sclk,      // Transfer clock pin
  output logic             o_mosi,      // Serial out pin (master out)
  input  wire logic        i_miso,      // Serial in pin (master in)
  output logic             o_tx_own,    // Serial out pin overridden
  output logic             o_rx_own     // Serial in pin overridden
);

  ums_pkg::ums_state_t q;
  ums_pkg::ums_state_t n;

  logic wr_status;
  logic wr_ctrl;
  logic wr_mode;
  logic wr_data;
  logic rd_pop;
  logic mspi;
  logic edge_go;
  logic done;
  logic load;

  function automatic logic [2:0] bit_pos(input logic       lsb,
                                         input logic [2:0] k);
    bit_pos = lsb ? k : 3'h7 - k;
  endfunction : bit_pos

  function automatic logic hit(input logic       s,
                               input logic [3:0] a,
                               input logic [3:0] ref_a);
    hit = s && (a == ref_a);
  endfunction : hit

  assign wr_status = hit(i_wr, i_addr, ums_pkg::ADDR_STATUS);
  assign wr_ctrl   = hit(i_wr, i_addr, ums_pkg::ADDR_CTRL);
  assign wr_mode   = hit(i_wr, i_addr, ums_pkg::ADDR_MODE);
  assign wr_data   = hit(i_wr, i_addr, ums_pkg::ADDR_DATA);
  assign rd_pop    = hit(i_rd, i_addr, ums_pkg::ADDR_DATA) && q.rxcnt != 2'h0;
  assign mspi      = q.mode_sel == ums_pkg::MODE_MSPI;
  assign edge_go   = q.busy && q.div == q.baud;
  assign done      = edge_go && q.edge_n == ums_pkg::LAST_EDGE;
  // Back-to-back: the buffer reloads in the cycle the last edge fires
  assign load      = mspi && q.txen_eff && q.txbuf_v
                     && (!q.busy || done);

  always_comb begin
    n = q;
    n.miso_s1 = i_miso;
    n.miso_s2 = q.miso_s1;

    // Read path, pop before push so a full buffer frees a slot
    n.rdata = 8'h00;
    if (i_rd) begin
      case (i_addr)
        ums_pkg::ADDR_STATUS:
          n.rdata = {q.rxcnt != 2'h0, q.txc, !q.txbuf_v, 5'h00};
        ums_pkg::ADDR_CTRL:
          n.rdata = {q.rxcie, q.txcie, q.beie, q.rxen, q.txen_req, 3'h0};
        ums_pkg::ADDR_MODE:
          n.rdata = {q.mode_sel, 3'h0, q.order, q.native_spi_phase, q.native_spi_polarity};
        ums_pkg::ADDR_DATA:
          n.rdata = q.rxf[0];
        ums_pkg::ADDR_BAUD_LO:
          n.rdata = q.baud[7:0];
        ums_pkg::ADDR_BAUD_HI:
          n.rdata = {4'h0, q.baud[11:8]};
        default:
          n.rdata = 8'h00;
      endcase
    end
    if (rd_pop) begin
      n.rxf[0] = q.rxf[1];
      n.rxcnt  = q.rxcnt - 2'h1;
    end

    // Shift engine
    if (q.busy && !mspi) begin
      n.busy = 1'b0;
    end else if (q.busy) begin
      if (edge_go) begin
        n.div    = 12'h000;
        n.sclk   = ~q.sclk;
        n.edge_n = q.edge_n + 4'h1;
        if (q.edge_n[0] == q.native_spi_phase) begin
          n.rxsh[bit_pos(q.order, q.bitn)] = q.miso_s2;
        end else if (q.native_spi_phase) begin
          n.bitn = q.edge_n[3:1];
        end else begin
          n.bitn = q.edge_n[3:1] + 3'h1;
        end
        n.mosi = q.txsh[bit_pos(q.order, n.bitn)];
      end else begin
        n.div = q.div + 12'h001;
      end
    end

    if (done) begin
      n.busy = 1'b0;
      // Newest byte is dropped when both levels hold unread data
      if (q.rxen && n.rxcnt != ums_pkg::RX_DEPTH) begin
        n.rxf[n.rxcnt[0]] = n.rxsh;
        n.rxcnt = n.rxcnt + 2'h1;
      end
    end

    // Transmit-complete: clears first so a same-cycle set wins
    if ((wr_status && i_wdata[ums_pkg::TXC_BIT]) || i_txc_ack) begin
      n.txc = 1'b0;
    end
    if (done && !load) begin
      n.txc = 1'b1;
    end

    if (load) begin
      n.busy    = 1'b1;
      n.txbuf_v = 1'b0;
      n.txsh    = q.txbuf;
      n.edge_n  = 4'h0;
      n.div     = 12'h000;
      n.bitn    = 3'h0;
      n.mosi    = q.txbuf[bit_pos(q.order, 3'h0)];
    end

    // Register writes; reserved write bits are ignored
    if (wr_data) begin
      n.txbuf   = i_wdata;
      n.txbuf_v = 1'b1;
    end
    if (wr_ctrl) begin
      n.rxcie    = i_wdata[ums_pkg::RXCIE_BIT];
      n.txcie    = i_wdata[ums_pkg::TXCIE_BIT];
      n.beie     = i_wdata[ums_pkg::BEIE_BIT];
      n.rxen     = i_wdata[ums_pkg::RXEN_BIT];
      n.txen_req = i_wdata[ums_pkg::TXEN_BIT];
      if (i_wdata[ums_pkg::TXEN_BIT]) begin
        n.txen_eff = 1'b1;
      end
    end
    if (!n.rxen) begin
      n.rxcnt = 2'h0;
    end
    if (wr_mode) begin
      n.mode_sel = i_wdata[ums_pkg::MODE_HI_BIT:ums_pkg::MODE_LO_BIT];
      n.order    = i_wdata[ums_pkg::ORDER_BIT];
      n.native_spi_phase     = i_wdata[ums_pkg::NATIVE_SPI_PHASE_BIT];
      n.native_spi_polarity     = i_wdata[ums_pkg::NATIVE_SPI_POLARITY_BIT];
    end
    if (hit(i_wr, i_addr, ums_pkg::ADDR_BAUD_LO)) begin
      n.baud[7:0] = i_wdata;
    end
    if (hit(i_wr, i_addr, ums_pkg::ADDR_BAUD_HI)) begin
      n.baud[11:8] = i_wdata[3:0];
    end

    // Disable of the transmitter waits for both stages to drain
    if (!n.txen_req && !n.busy && !n.txbuf_v) begin
      n.txen_eff = 1'b0;
    end
    if (!n.busy) begin
      n.sclk = n.native_spi_polarity;
    end

    n.irq_rxc  = n.rxcie && i_gie && n.rxcnt != 2'h0;
    n.irq_txc  = n.txcie && i_gie && n.txc;
    n.irq_udre = n.beie && i_gie && !n.txbuf_v;
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      q <= ums_pkg::STATE_RST;
    end else begin
      q <= n;
    end
  end

  assign o_rdata    = q.rdata;
  assign o_irq_rxc  = q.irq_rxc;
  assign o_irq_txc  = q.irq_txc;
  assign o_irq_udre = q.irq_udre;
  assign o_sclk     = q.sclk;
  assign o_mosi     = q.mosi;
  assign o_tx_own   = q.txen_eff;
  assign o_rx_own   = q.rxen;

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_srst);

  mode_gate_a: assert property (
    !mspi |=> !q.busy
  ) else $error("Engine busy outside master SPI mode");

  out_bit_a: assert property (
    q.busy |-> o_mosi == q.txsh[bit_pos(q.order, q.bitn)]
  ) else $error("Serial out bit does not follow bit order");

  clk_hold_a: assert property (
    q.busy && mspi && q.div != q.baud |=> $stable(o_sclk)
  ) else $error("Transfer clock moved between divisor edges");

  clk_toggle_a: assert property (
    edge_go && mspi |=> o_sclk != $past(o_sclk)
  ) else $error("Transfer clock missed a divisor edge");

  idle_level_a: assert property (
    !q.busy |-> o_sclk == q.native_spi_polarity
  ) else $error("Idle transfer clock not at polarity level");

  rx_flush_a: assert property (
    wr_ctrl && !i_wdata[ums_pkg::RXEN_BIT] |=> q.rxcnt == 2'h0 ##1 !o_irq_rxc
  ) else $error("Receiver disable did not flush buffer");

  tx_drain_a: assert property (
    $fell(q.txen_eff) |-> !q.busy && !q.txbuf_v
  ) else $error("Transmitter released with data pending");

  rx_keep_a: assert property (
    q.rxcnt == ums_pkg::RX_DEPTH && !rd_pop && q.rxen |=> q.rxf == $past(q.rxf)
  ) else $error("Full receive buffer lost an older byte");

  txc_set_a: assert property (
    $rose(q.txc) |-> $past(q.busy) && !q.busy
  ) else $error("Transmit-complete set without frame end");

  irq_gate_a: assert property (
    o_irq_txc |-> $past(i_gie) && q.txc && q.txcie
  ) else $error("Transmit-complete interrupt without its enables");

  tx_needed_a: assert property (
    q.busy |-> q.txen_eff
  ) else $error("Transfer running without transmitter");

  frame_len_a: assert property (
    done |=> q.edge_n == 4'h0
  ) else $error("Frame did not end after sixteen edges");

  // Load and buffer checks
  load_start_a: assert property (
    load |=> q.busy && q.edge_n == 4'h0 && q.bitn == 3'h0 && q.div == 12'h000
  ) else $error("Load did not start a fresh frame");

  load_copy_a: assert property (
    load |=> q.txsh == $past(q.txbuf)
  ) else $error("Shifter did not take the buffered byte");

  buf_free_a: assert property (
    load && !wr_data |=> !q.txbuf_v
  ) else $error("Buffer still full after load");

  buf_fill_a: assert property (
    wr_data |=> q.txbuf_v && q.txbuf == $past(i_wdata)
  ) else $error("Data write did not land in the buffer");

  first_lsb_a: assert property (
    load && q.order |=> o_mosi == $past(q.txbuf[0])
  ) else $error("LSB-first frame did not open with bit 0");

  first_msb_a: assert property (
    load && !q.order |=> o_mosi == $past(q.txbuf[7])
  ) else $error("MSB-first frame did not open with bit 7");

  // Divider and edge counting
  div_count_a: assert property (
    q.busy && mspi && !edge_go |=> q.div == $past(q.div) + 12'h001
  ) else $error("Divisor counter did not advance");

  edge_count_a: assert property (
    edge_go && mspi && !done |=> q.edge_n == $past(q.edge_n) + 4'h1
  ) else $error("Edge counter did not advance");

  sample_bit_a: assert property (
    edge_go && mspi && q.edge_n[0] == q.native_spi_phase
    |=> q.rxsh[bit_pos($past(q.order), $past(q.bitn))] == $past(q.miso_s2)
  ) else $error("Serial in bit not sampled on its edge");

  no_frame_a: assert property (
    !q.txen_eff |=> !q.busy
  ) else $error("Transfer started without transmitter");

  // Interrupt gating
  rxc_irq_a: assert property (
    o_irq_rxc |-> q.rxcnt != 2'h0 && q.rxcie && $past(i_gie)
  ) else $error("Receive interrupt without its enables");

  udre_irq_a: assert property (
    o_irq_udre |-> !q.txbuf_v && q.beie && $past(i_gie)
  ) else $error("Buffer-empty interrupt without its enables");

  txc_irq_a: assert property (
    q.txc && q.txcie && $past(i_gie) |-> o_irq_txc
  ) else $error("Transmit-complete interrupt missing");

  // Receive buffer
  rx_depth_a: assert property (
    q.rxcnt <= ums_pkg::RX_DEPTH
  ) else $error("Receive buffer count beyond its depth");

  rx_off_a: assert property (
    !q.rxen |-> q.rxcnt == 2'h0
  ) else $error("Disabled receiver holds data");

  rx_push_a: assert property (
    done && q.rxen && q.rxcnt == 2'h0 && !wr_ctrl |=> q.rxcnt == 2'h1
  ) else $error("Received byte not stored");

  rx_pop_a: assert property (
    rd_pop && !done && !wr_ctrl |=> q.rxcnt == $past(q.rxcnt) - 2'h1
  ) else $error("Data read did not pop the buffer");

  data_read_a: assert property (
    i_rd && i_addr == ums_pkg::ADDR_DATA |=> o_rdata == $past(q.rxf[0])
  ) else $error("Data read did not return oldest byte");

  // Register port
  status_low_a: assert property (
    i_rd && i_addr == ums_pkg::ADDR_STATUS |=> o_rdata[4:0] == 5'h00
  ) else $error("Error flags did not read as zero");

  ctrl_low_a: assert property (
    i_rd && i_addr == ums_pkg::ADDR_CTRL |=> o_rdata[2:0] == 3'h0
  ) else $error("Reserved control bits read nonzero");

  mode_mid_a: assert property (
    i_rd && i_addr == ums_pkg::ADDR_MODE |=> o_rdata[5:3] == 3'h0
  ) else $error("Reserved mode bits read nonzero");

  rd_idle_a: assert property (
    !i_rd |=> o_rdata == 8'h00
  ) else $error("Read data outside the read cycle");

  rd_unmapped_a: assert property (
    i_rd && i_addr > ums_pkg::ADDR_BAUD_HI |=> o_rdata == 8'h00
  ) else $error("Unmapped read returned data");

  mode_take_a: assert property (
    wr_mode |=> q.order == $past(i_wdata[ums_pkg::ORDER_BIT])
      && q.native_spi_phase == $past(i_wdata[ums_pkg::NATIVE_SPI_PHASE_BIT])
      && q.native_spi_polarity == $past(i_wdata[ums_pkg::NATIVE_SPI_POLARITY_BIT])
      && q.mode_sel == $past(i_wdata[7:6])
  ) else $error("Mode write did not take all fields");

  ctrl_take_a: assert property (
    wr_ctrl |=> q.rxen == $past(i_wdata[ums_pkg::RXEN_BIT])
      && q.txen_req == $past(i_wdata[ums_pkg::TXEN_BIT])
  ) else $error("Control write did not take enables");

  baud_lo_a: assert property (
    hit(i_wr, i_addr, ums_pkg::ADDR_BAUD_LO) |=> q.baud[7:0] == $past(i_wdata)
  ) else $error("Low divisor write lost");

  baud_hi_a: assert property (
    hit(i_wr, i_addr, ums_pkg::ADDR_BAUD_HI)
    |=> q.baud[11:8] == $past(i_wdata[3:0])
  ) else $error("High divisor write lost");

  // Transmit-complete and pin ownership
  txc_clear_a: assert property (
    i_txc_ack && !(done && !load) |=> !q.txc
  ) else $error("Serviced transmit-complete not cleared");

  txc_win_a: assert property (
    done && !load |=> q.txc
  ) else $error("Frame end did not set transmit-complete");

  tx_take_a: assert property (
    wr_ctrl && i_wdata[ums_pkg::TXEN_BIT] |=> o_tx_own
  ) else $error("Transmitter enable did not take the pin");

  tx_keep_a: assert property (
    q.txen_eff && q.txbuf_v |=> o_tx_own
  ) else $error("Transmitter released with buffer full");

  tx_release_a: assert property (
    !q.txen_req && !q.busy && !q.txbuf_v && !wr_ctrl && !wr_data
    |=> !o_tx_own
  ) else $error("Idle disabled transmitter kept the pin");

endmodule : ums_master_spi

// ===== tb/ums_spi_slave.sv
// SPI slave model facing the master-only serial port.
// Assumes the bench holds i_clear while the port is reconfigured.
`timescale 1ns/1ps
module ums_spi_slave #(
  parameter logic [7:0] FIRST = 8'ha5  // Answer of the very first frame
) (
  input  wire logic       i_clear,   // Hold edge count at zero
  input  wire logic       i_sclk,    // Transfer clock from the master
  input  wire logic       i_mosi,    // Master out
  input  wire logic       i_native_spi_phase,    // Phase the master uses
  input  wire logic       i_order,   // One when LSB goes first
  output logic            o_miso,    // Master in
  output logic      [7:0] o_rx,      // Last byte received
  output int              o_frames   // Frames completed
);
  logic [7:0] out_q = FIRST;
  logic [7:0] acc = 8'h00;
  int         n = 0;
  initial begin
    o_miso = 1'b0;
    o_rx = 8'h00;
    o_frames = 0;
  end
  function automatic logic pick(input int b);
    return i_order ? out_q[b] : out_q[7-b];
  endfunction : pick
  // Order may settle after clear rises, so both reload the first bit
  always @(i_clear or i_order) begin
    if (i_clear) begin
      n = 0;
      o_miso = pick(0);
    end
  end
  // Echoes each byte in the next frame, like a plain shift slave
  always @(i_sclk) begin
    if (!i_clear) begin
      if (n[0] == i_native_spi_phase) acc[i_order ? n/2 : 7-n/2] = i_mosi;
      if (n == 15) begin
        out_q = acc;
        o_rx = acc;
        o_frames++;
      end
      if (n[0] != i_native_spi_phase) o_miso = pick(i_native_spi_phase ? n/2 : ((n+1)/2)%8);
      else if (n == 15) o_miso = ~o_miso;  // No stale bit past the frame
      n = (n+1)%16;
    end
  end
endmodule : ums_spi_slave

// ===== tb/testbench.sv
// Self-checking bench for the master-only SPI serial port.
// Assumes the slave model ums_spi_slave and a 100 MHz clock.
`timescale 1ns/1ps
module testbench;
  logic       sys_clk = 1'b0;
  logic       srst = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic       wr = 1'b0;
  logic       rd = 1'b0;
  logic       gie = 1'b0;
  logic       ack = 1'b0;
  logic       clr = 1'b0;
  logic       look = 1'b0;
  logic       cph = 1'b0;
  logic       ord = 1'b0;
  logic       rd_d = 1'b0;
  logic [7:0] echo = 8'ha5;
  logic [7:0] rdata, slv_rx;
  logic       irq_rxc, irq_txc, irq_udre, sclk, mosi, miso, tx_own, rx_own;
  int         slv_frames;
  int         nf = 0;
  int         fail_count = 0;
  int         samples_checked = 0;
  int         cyc = 0;
  logic [7:0] exp_q[$], tx_q[$], rxe[$];

  ums_master_spi dut (
    .i_sys_clk(sys_clk), .i_srst(srst), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_gie(gie), .i_txc_ack(ack),
    .o_irq_rxc(irq_rxc), .o_irq_txc(irq_txc), .o_irq_udre(irq_udre),
    .o_sclk(sclk), .o_mosi(mosi), .i_miso(miso), .o_tx_own(tx_own),
    .o_rx_own(rx_own));
  ums_spi_slave slv (
    .i_clear(clr), .i_sclk(sclk), .i_mosi(mosi), .i_native_spi_phase(cph),
    .i_order(ord), .o_miso(miso), .o_rx(slv_rx), .o_frames(slv_frames));

  always #5 sys_clk = ~sys_clk;

  task automatic check(input string nm, input logic [7:0] seen,
                       input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : summarize

  // Kind 1 writes, 2 reads, 3 probes pins; 2 and 3 note d as expected
  task automatic op(input int k, input logic [3:0] a, input logic [7:0] d);
    if (k > 1) exp_q.push_back(d);
    wr <= (k == 1);
    rd <= (k == 2);
    look <= (k == 3);
    addr <= a;
    wdata <= d;
    @(posedge sys_clk);
  endtask : op

  task automatic send(input logic [7:0] b);
    op(1, ums_pkg::ADDR_DATA, b);
    tx_q.push_back(b);
    rxe.push_back(echo);
    echo = b;
    nf++;
  endtask : send

  task automatic wf();
    op(0, 4'h0, 8'h00);
    for (int t = 0; t < 3000 && slv_frames < nf; t++) @(posedge sys_clk);
    repeat (4) @(posedge sys_clk);
  endtask : wf

  always @(posedge sys_clk) begin
    if (rd_d) check("rdata", rdata, exp_q.pop_front());
    if (look) check("pins", {2'b00, irq_rxc, irq_txc, irq_udre, tx_own,
                             rx_own, sclk}, exp_q.pop_front());
    rd_d <= rd & ~srst;
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      summarize();
    end
  end
  always @(slv_frames) check("frame", slv_rx, tx_q.pop_front());

  initial begin
    logic g;
    void'($urandom(32'h9179));
    clr <= 1'b1;
    repeat (6) @(posedge sys_clk);
    srst <= 1'b0;
    op(2, ums_pkg::ADDR_STATUS, 8'h20);
    op(2, ums_pkg::ADDR_CTRL, 8'h00);
    op(2, ums_pkg::ADDR_MODE, 8'h06);
    op(2, 4'h9, 8'h00);
    op(3, 4'h0, 8'h00);
    op(1, ums_pkg::ADDR_CTRL, 8'h10);
    op(1, ums_pkg::ADDR_MODE, 8'hc0);
    op(1, ums_pkg::ADDR_BAUD_LO, 8'h03);  // 80 ns transfer clock
    op(1, ums_pkg::ADDR_BAUD_HI, 8'hf0);
    op(2, ums_pkg::ADDR_BAUD_LO, 8'h03);
    op(2, ums_pkg::ADDR_BAUD_HI, 8'h00);
    send(8'h5a);
    op(0, 4'h0, 8'h00);
    clr <= 1'b0;
    repeat (60) @(posedge sys_clk);
    op(3, 4'h0, 8'h02);
    op(2, ums_pkg::ADDR_STATUS, 8'h00);
    op(1, ums_pkg::ADDR_CTRL, 8'hf8);
    wf();
    op(2, ums_pkg::ADDR_DATA, rxe.pop_front());
    op(1, ums_pkg::ADDR_STATUS, 8'h40);
    // Every polarity, phase and order pairing, two frames back to back
    for (int m = 0; m < 8; m++) begin
      g = 1'($urandom);
      clr <= 1'b1;
      gie <= g;
      ord <= m[2];
      cph <= m[1];
      op(1, ums_pkg::ADDR_MODE, {5'b11000, m[2:0]});
      op(2, ums_pkg::ADDR_MODE, {5'b11000, m[2:0]});
      op(3, 4'h0, {2'b00, 1'b0, 1'b0, g, 1'b1, 1'b1, m[0]});
      clr <= 1'b0;
      send(8'($urandom));
      send(8'($urandom));
      op(2, ums_pkg::ADDR_STATUS, 8'h00);
      wf();
      op(3, 4'h0, {2'b00, g, g, g, 1'b1, 1'b1, m[0]});
      op(2, ums_pkg::ADDR_STATUS, 8'he0);
      op(2, ums_pkg::ADDR_DATA, rxe.pop_front());
      op(2, ums_pkg::ADDR_DATA, rxe.pop_front());
      op(2, ums_pkg::ADDR_STATUS, 8'h60);
      if (m[0]) begin
        ack <= 1'b1;
        op(0, 4'h0, 8'h00);
        ack <= 1'b0;
      end else begin
        op(1, ums_pkg::ADDR_STATUS, 8'h40);
      end
      op(2, ums_pkg::ADDR_STATUS, 8'h20);
    end
    send(8'($urandom));
    send(8'($urandom));
    wf();
    send(8'($urandom));
    wf();
    op(2, ums_pkg::ADDR_DATA, rxe.pop_front());
    op(2, ums_pkg::ADDR_DATA, rxe.pop_front());
    void'(rxe.pop_front());
    op(2, ums_pkg::ADDR_STATUS, 8'h60);
    send(8'($urandom));
    send(8'($urandom));
    op(1, ums_pkg::ADDR_CTRL, 8'h10);
    wf();
    op(3, 4'h0, 8'h03);
    op(1, ums_pkg::ADDR_CTRL, 8'h00);
    op(2, ums_pkg::ADDR_STATUS, 8'h60);
    rxe.delete();
    // Non-SPI mode code must leave the engine idle
    clr <= 1'b1;
    op(1, ums_pkg::ADDR_MODE, 8'h40);
    op(1, ums_pkg::ADDR_CTRL, 8'h08);
    op(1, ums_pkg::ADDR_DATA, 8'hff);
    op(0, 4'h0, 8'h00);
    repeat (80) @(posedge sys_clk);
    op(2, ums_pkg::ADDR_STATUS, 8'h40);
    repeat (3) op(0, 4'h0, 8'h00);
    summarize();
  end
endmodule : testbench
